// >>> inc/csf_core_map.vh
`ifndef CSF_CORE_MAP_VH
`define CSF_CORE_MAP_VH
// I/O and data-space layout
`define CSF_IO_DS_BASE    8'h20
`define CSF_IO_DS_LAST    8'h5F
`define CSF_EXT_DS_BASE   8'h60
`define CSF_STATUS_DS     8'h5F
`define CSF_STATUS_IO     6'h3F
`define CSF_STATUS_RST    8'h00
`define CSF_PTR_X_LO      5'h1A
`define CSF_PTR_Y_LO      5'h1C
`define CSF_PTR_Z_LO      5'h1E
// Status register bit positions
`define CSF_BIT_I 7
`define CSF_BIT_T 6
`define CSF_BIT_H 5
`define CSF_BIT_S 4
`define CSF_BIT_V 3
`define CSF_BIT_N 2
`define CSF_BIT_Z 1
`define CSF_BIT_C 0
// Micro-op codes presented on op_code
`define CSF_OP_NOP   4'h0
`define CSF_OP_ADD   4'h1
`define CSF_OP_ADC   4'h2
`define CSF_OP_SUB   4'h3
`define CSF_OP_AND   4'h4
`define CSF_OP_OR    4'h5
`define CSF_OP_XOR   4'h6
`define CSF_OP_MOV   4'h7
`define CSF_OP_BIT_STORE_TO_FLAG     4'h8
`define CSF_OP_BIT_LOAD_FROM_FLAG    4'h9
`define CSF_OP_SET_IRQ_GATE          4'hA
`define CSF_OP_CLEAR_IRQ_GATE        4'hB
`define CSF_OP_RETURN_FROM_INTERRUPT 4'hC
`define CSF_OP_CALL  4'hD
`define CSF_OP_SELF_PROGRAM_WRITE    4'hE
`define CSF_OP_LDI   4'hF
`define CSF_IRQ_N    8
`define CSF_PC_W     16
`endif

// >>> hdl/csf_core_slice.v
// Contract
// - 32 byte registers, two read, one write
// - Prefetch next word while current executes
// - Three 16-bit pointer pairs from registers
// - Self-program write only from boot section
// - Lowest pending vector served first
// - 64 I/O at data 0x20-0x5F, direct too
// - Extended 0x60-0xFF only by load/store
// - Direct I/O address is data minus 0x20
// - Status at 0x5F/I/O 0x3F, resets zero
// - Status never saved or restored by hardware
// - Flags updated after every add, subtract and logic operation
// - No interrupt while global enable clear
// - Accept clears enable; return sets it
// - Set/clear enable instructions under program control
// - T flag for bit store and load
// - Half carry marks nibble carry
// - Sign equals negative xor overflow
// - Overflow on signed range overflow
// - Negative when result top bit set
// - Return PC pushed to data stack
`timescale 1ns/1ps
`include "csf_core_map.vh"
module csf_core_slice (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire [15:0] prog_word,
	input  wire [3:0]  op_code,
	input  wire [4:0]  op_dst,
	input  wire [4:0]  op_src,
	input  wire [7:0]  op_imm,
	input  wire [2:0]  op_bit,
	input  wire        op_valid,
	input  wire        io_direct,
	input  wire        ds_access,
	input  wire        ds_write,
	input  wire [7:0]  ds_addr,
	input  wire [7:0]  ds_wdata,
	input  wire [15:0] call_target,
	input  wire [15:0] boot_start,
	input  wire [15:0] stack_ptr,
	input  wire [7:0]  irq_pending,
	output reg  [15:0] prog_addr,
	output reg  [15:0] fetched_word,
	output reg  [7:0]  processor_status_flags,
	output reg  [7:0]  ds_rdata,
	output reg         ext_sel,
	output reg  [7:0]  ext_addr,
	output reg         ext_write,
	output reg  [7:0]  ext_wdata,
	output reg  [15:0] ptr_x,
	output reg  [15:0] ptr_y,
	output reg  [15:0] ptr_z,
	output reg         stack_write,
	output reg  [15:0] stack_addr,
	output reg  [15:0] stack_data,
	output reg         self_program_write,
	output reg  [2:0]  irq_taken_id,
	output reg         irq_taken,
	output reg  [15:0] irq_vector
);

	// ****************************************
	// Storage and helpers
	// ****************************************
	reg [7:0] work_reg [0:31];
	reg [7:0] io_reg   [0:63];
	reg [15:0] pc_reg;
	integer i;

	// Pair two working registers into one pointer
	function [15:0] pair;
		input [4:0] lo;
		begin
			pair = {work_reg[lo + 5'h01], work_reg[lo]};
		end
	endfunction

	// Lowest-index pending line wins
	function [3:0] prio;
		input [7:0] req;
		integer k;
		begin
			prio = 4'h8;
			for (k = `CSF_IRQ_N - 1; k >= 0; k = k - 1) begin
				if (req[k])
					prio = k[3:0];
			end
		end
	endfunction

	// Data-space address to I/O slot; wraps inside the 64 slots
	function [5:0] io_index;
		input [7:0] a;
		reg   [7:0] ofs;
		begin
			ofs = a - `CSF_IO_DS_BASE;
			io_index = ofs[5:0];
		end
	endfunction

	// Vectors sit two words apart, line 0 at the bottom
	function [15:0] vec_addr;
		input [3:0] id;
		begin
			vec_addr = {11'h000, id, 1'b0};
		end
	endfunction

	// ****************************************
	// ALU and flag computation
	// ****************************************
	reg [7:0] rd_v;
	reg [7:0] rr_v;
	reg [8:0] sum;
	reg [7:0] res;
	reg       wr_en;
	reg [7:0] flags_next;
	reg       arith;

	always @* begin
		rd_v = work_reg[op_dst];
		rr_v = (op_code == `CSF_OP_LDI) ? op_imm : work_reg[op_src];
		sum = 9'h000;
		res = rd_v;
		wr_en = 1'b0;
		arith = 1'b0;
		flags_next = processor_status_flags;
		case (op_code)
		`CSF_OP_ADD, `CSF_OP_ADC: begin
			sum = {1'b0, rd_v} + {1'b0, rr_v}
				+ {8'h00, (op_code == `CSF_OP_ADC) & processor_status_flags[`CSF_BIT_C]};
			res = sum[7:0];
			wr_en = 1'b1;
			arith = 1'b1;
			flags_next[`CSF_BIT_H] = (rd_v[3] & rr_v[3]) | (rr_v[3] & ~res[3])
				| (~res[3] & rd_v[3]);
			flags_next[`CSF_BIT_V] = (rd_v[7] & rr_v[7] & ~res[7])
				| (~rd_v[7] & ~rr_v[7] & res[7]);
			flags_next[`CSF_BIT_C] = sum[8];
		end
		`CSF_OP_SUB: begin
			sum = {1'b0, rd_v} - {1'b0, rr_v};
			res = sum[7:0];
			wr_en = 1'b1;
			arith = 1'b1;
			flags_next[`CSF_BIT_H] = (~rd_v[3] & rr_v[3]) | (rr_v[3] & res[3])
				| (res[3] & ~rd_v[3]);
			flags_next[`CSF_BIT_V] = (rd_v[7] & ~rr_v[7] & ~res[7])
				| (~rd_v[7] & rr_v[7] & res[7]);
			flags_next[`CSF_BIT_C] = sum[8];
		end
		`CSF_OP_AND, `CSF_OP_OR, `CSF_OP_XOR: begin
			res = (op_code == `CSF_OP_AND) ? (rd_v & rr_v) :
				(op_code == `CSF_OP_OR) ? (rd_v | rr_v) : (rd_v ^ rr_v);
			wr_en = 1'b1;
			arith = 1'b1;
			flags_next[`CSF_BIT_V] = 1'b0;
		end
		`CSF_OP_MOV, `CSF_OP_LDI: begin
			res = rr_v;
			wr_en = 1'b1;
		end
		`CSF_OP_BIT_STORE_TO_FLAG:
			flags_next[`CSF_BIT_T] = rd_v[op_bit];
		`CSF_OP_BIT_LOAD_FROM_FLAG: begin
			res[op_bit] = processor_status_flags[`CSF_BIT_T];
			wr_en = 1'b1;
		end
		`CSF_OP_SET_IRQ_GATE:
			flags_next[`CSF_BIT_I] = 1'b1;
		`CSF_OP_CLEAR_IRQ_GATE:
			flags_next[`CSF_BIT_I] = 1'b0;
		`CSF_OP_RETURN_FROM_INTERRUPT:
			flags_next[`CSF_BIT_I] = 1'b1;
		default: begin
			res = rd_v;
		end
		endcase
		// Common result flags for the add, subtract and logic operations
		if (arith) begin
			flags_next[`CSF_BIT_N] = res[7];
			flags_next[`CSF_BIT_Z] = (res == 8'h00);
		end
		flags_next[`CSF_BIT_S] = flags_next[`CSF_BIT_N] ^ flags_next[`CSF_BIT_V];
		if (!op_valid) begin
			wr_en = 1'b0;
			flags_next = processor_status_flags;
		end
	end

	// ****************************************
	// Address decode for data space and I/O
	// ****************************************
	reg [7:0] eff_addr;
	reg       hit_io;
	reg       hit_ext;
	reg       hit_status;

	// Direct I/O numbers are lifted by 0x20 to share one decoder
	always @* begin
		eff_addr = io_direct ? ({2'b00, ds_addr[5:0]} + `CSF_IO_DS_BASE) : ds_addr;
		hit_io = ds_access && (eff_addr >= `CSF_IO_DS_BASE)
			&& (eff_addr <= `CSF_IO_DS_LAST);
		hit_ext = ds_access && !io_direct && (eff_addr >= `CSF_EXT_DS_BASE);
		hit_status = hit_io && (eff_addr == `CSF_STATUS_DS);
	end

	// ****************************************
	// Interrupt acceptance
	// ****************************************
	reg [3:0] win;
	reg       take;

	always @* begin
		win = prio(irq_pending);
		take = processor_status_flags[`CSF_BIT_I] && (irq_pending != 8'h00);
	end

	// ****************************************
	// Sequential state
	// ****************************************
	// Flags are not stacked on interrupt entry: software owns that
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			processor_status_flags <= `CSF_STATUS_RST;
			pc_reg <= 16'h0000;
			prog_addr <= 16'h0000;
			fetched_word <= 16'h0000;
			ds_rdata <= 8'h00;
			ext_sel <= 1'b0;
			ext_addr <= 8'h00;
			ext_write <= 1'b0;
			ext_wdata <= 8'h00;
			ptr_x <= 16'h0000;
			ptr_y <= 16'h0000;
			ptr_z <= 16'h0000;
			stack_write <= 1'b0;
			stack_addr <= 16'h0000;
			stack_data <= 16'h0000;
			self_program_write <= 1'b0;
			irq_taken <= 1'b0;
			irq_taken_id <= 3'h0;
			irq_vector <= 16'h0000;
			for (i = 0; i < 32; i = i + 1)
				work_reg[i] <= 8'h00;
			for (i = 0; i < 64; i = i + 1)
				io_reg[i] <= 8'h00;
		end else begin
			// Prefetch overlaps execution of the current word
			fetched_word <= prog_word;
			pc_reg <= pc_reg + 16'h0001;
			prog_addr <= pc_reg + 16'h0001;
			if (wr_en)
				work_reg[op_dst] <= res;
			processor_status_flags <= flags_next;
			// Pointers follow the pairs one clock behind a register write;
			// a reader that needs the new value must allow that clock
			ptr_x <= pair(`CSF_PTR_X_LO);
			ptr_y <= pair(`CSF_PTR_Y_LO);
			ptr_z <= pair(`CSF_PTR_Z_LO);
			// Boot check guards the application area
			self_program_write <= op_valid && (op_code == `CSF_OP_SELF_PROGRAM_WRITE)
				&& (pc_reg >= boot_start);
			stack_write <= 1'b0;
			irq_taken <= 1'b0;
			// A call in the same clock holds a pending interrupt back one clock
			if (op_valid && op_code == `CSF_OP_CALL) begin
				stack_write <= 1'b1;
				stack_addr <= stack_ptr;
				stack_data <= pc_reg + 16'h0001;
				pc_reg <= call_target;
				prog_addr <= call_target;
			end else if (take) begin
				processor_status_flags[`CSF_BIT_I] <= 1'b0;
				irq_taken <= 1'b1;
				irq_taken_id <= win[2:0];
				irq_vector <= vec_addr(win);
				stack_write <= 1'b1;
				stack_addr <= stack_ptr;
				stack_data <= pc_reg;
				pc_reg <= vec_addr(win);
				prog_addr <= vec_addr(win);
			end
			// Data-space reads and writes
			ds_rdata <= 8'h00;
			if (ds_access && !io_direct && eff_addr < `CSF_IO_DS_BASE)
				ds_rdata <= work_reg[eff_addr[4:0]];
			if (hit_status)
				ds_rdata <= processor_status_flags;
			else if (hit_io)
				ds_rdata <= io_reg[io_index(eff_addr)];
			if (ds_write && ds_access && !io_direct && eff_addr < `CSF_IO_DS_BASE)
				work_reg[eff_addr[4:0]] <= ds_wdata;
			if (ds_write && hit_status)
				processor_status_flags <= ds_wdata;
			else if (ds_write && hit_io)
				io_reg[io_index(eff_addr)] <= ds_wdata;
			ext_sel <= hit_ext;
			ext_addr <= eff_addr;
			ext_write <= hit_ext && ds_write;
			ext_wdata <= ds_wdata;
		end
	end

endmodule

// >>> test/csf_core_monitor.sv
`timescale 1ns/1ps
`include "csf_core_map.vh"
// ******************
// Port checker
// ******************
module csf_core_monitor (
	input wire       sys_clk,
	input wire       reset,
	input wire [3:0] op_code,
	input wire       op_valid,
	input wire       io_direct,
	input wire       ds_access,
	input wire       ds_write,
	input wire [7:0] ds_addr,
	input wire [7:0] ds_wdata,
	input wire [7:0] irq_pending,
	input wire [7:0] processor_status_flags,
	input wire       ext_sel,
	input wire       irq_taken,
	input wire [2:0] irq_taken_id,
	input wire [15:0] irq_vector,
	input wire       stack_write
);
	wire [7:0] f = processor_status_flags;
	// One domain, so clock and reset are stated once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_gate; irq_taken |-> $past(f[7]); endproperty
	a_gate: assert property (p_gate) else $error("irq taken with gate clear");
	property p_clr; irq_taken |-> !f[7]; endproperty
	a_clr: assert property (p_clr) else $error("gate left set on irq");
	property p_prio; irq_taken |-> (($past(irq_pending) >> irq_taken_id) & 8'h01) == 8'h01
		&& ($past(irq_pending) & ((8'h01 << irq_taken_id) - 8'h01)) == 8'h00; endproperty
	a_prio: assert property (p_prio) else $error("irq not lowest pending");
	property p_vec; irq_taken |-> irq_vector == {12'h000, irq_taken_id, 1'b0}; endproperty
	a_vec: assert property (p_vec) else $error("irq vector wrong");
	property p_push; irq_taken |-> stack_write; endproperty
	a_push: assert property (p_push) else $error("irq without push");
	property p_ext; ds_access && io_direct |=> !ext_sel; endproperty
	a_ext: assert property (p_ext) else $error("direct io reached ext");
	property p_ds; ds_access && ds_write && !io_direct && ds_addr == 8'h5F
		|=> f == $past(ds_wdata); endproperty
	a_ds: assert property (p_ds) else $error("status data write lost");
	property p_io; ds_access && ds_write && io_direct && ds_addr[5:0] == 6'h3F
		|=> f == $past(ds_wdata); endproperty
	a_io: assert property (p_io) else $error("status io write lost");
	property p_sign; op_valid && op_code == `CSF_OP_ADD && !ds_access
		|=> f[4] == (f[2] ^ f[3]); endproperty
	a_sign: assert property (p_sign) else $error("sign not n xor v");
	property p_sei; op_valid && op_code == `CSF_OP_SET_IRQ_GATE && !ds_access
		&& irq_pending == 8'h00
		|=> f[7]; endproperty
	a_sei: assert property (p_sei) else $error("gate not set");
endmodule
bind csf_core_slice csf_core_monitor u_mon (.*);

// >>> test/csf_prog_mem.sv
`timescale 1ns/1ps
// ******************
// Program memory model
// ******************
module csf_prog_mem (
	input  wire [15:0] prog_addr,
	output wire [15:0] prog_word
);
	// Word is a scramble of its address, so a stale fetch shows up
	assign prog_word = {prog_addr[7:0] ^ 8'hA5, prog_addr[15:8]};
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`include "csf_core_map.vh"
module tb;
	logic sys_clk, reset, op_valid, io_direct, ds_access, ds_write;
	logic [3:0] op_code;
	logic [4:0] op_dst, op_src;
	logic [2:0] op_bit;
	logic [7:0] op_imm, ds_addr, ds_wdata, irq_pending;
	logic [15:0] call_target, boot_start, stack_ptr;
	wire [15:0] prog_word, prog_addr, fetched_word, ptr_x, ptr_y, ptr_z;
	wire [15:0] stack_addr, stack_data, irq_vector;
	wire [7:0] processor_status_flags, ds_rdata, ext_addr, ext_wdata;
	wire [2:0] irq_taken_id;
	wire ext_sel, ext_write, stack_write, self_program_write, irq_taken;
	int fail_count = 0;
	int check_count = 0;
	csf_core_slice u_dut (.*);
	csf_prog_mem u_mem (.*);
	// ******************
	// Tasks
	// ******************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Op held one cycle; the answer is read just after the sampling edge
	task op(input logic [3:0] c, input logic [4:0] d, input logic [4:0] s, input logic [7:0] v);
		@(posedge sys_clk);
		op_code <= c;
		op_dst <= d;
		op_src <= s;
		op_imm <= v;
		op_bit <= v[2:0];
		op_valid <= 1'b1;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		#1;
	endtask
	task ds(input logic io, input logic [7:0] a, input logic [7:0] w, input logic wr);
		@(posedge sys_clk);
		ds_access <= 1'b1;
		ds_write <= wr;
		io_direct <= io;
		ds_addr <= a;
		ds_wdata <= w;
		@(posedge sys_clk);
		ds_access <= 1'b0;
		#1;
	endtask
	task irq(input logic [7:0] p);
		@(posedge sys_clk);
		irq_pending <= p;
		@(posedge sys_clk);
		irq_pending <= 8'h00;
		#1;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ******************
	// Clock, watchdog, tests
	// ******************
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Tests need under 100 cycles; 800 leaves ample margin
	initial begin
		#20000;
		fail_count++;
		end_sim;
	end
	initial begin
		{reset, op_valid, io_direct, ds_access, ds_write} = 5'h10;
		{op_code, op_dst, op_src, op_imm, op_bit, ds_addr, ds_wdata, irq_pending} = 0;
		call_target = 16'h9000;
		boot_start = 16'h8000;
		stack_ptr = 16'h08FF;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk(processor_status_flags, 16'h0000);
		op(`CSF_OP_LDI, 5'd0, 5'd0, 8'h7F);
		op(`CSF_OP_LDI, 5'd1, 5'd0, 8'h01);
		op(`CSF_OP_ADD, 5'd0, 5'd1, 8'h00);
		chk(processor_status_flags, 16'h002C);
		op(`CSF_OP_SUB, 5'd1, 5'd1, 8'h00);
		chk(processor_status_flags, 16'h0002);
		op(`CSF_OP_LDI, 5'd27, 5'd0, 8'h12);
		op(`CSF_OP_LDI, 5'd26, 5'd0, 8'h00);
		chk(ptr_x, 16'h1200);
		op(`CSF_OP_BIT_STORE_TO_FLAG, 5'd0, 5'd0, 8'h07);
		chk(processor_status_flags, 16'h0042);
		op(`CSF_OP_LDI, 5'd28, 5'd0, 8'h34);
		op(`CSF_OP_LDI, 5'd31, 5'd0, 8'h5A);
		op(`CSF_OP_BIT_LOAD_FROM_FLAG, 5'd26, 5'd0, 8'h03);
		// Pointers trail a register write by one clock
		@(posedge sys_clk);
		#1;
		chk(ptr_x, 16'h1208);
		chk(ptr_y, 16'h0034);
		chk(ptr_z, 16'h5A00);
		$display("test alu done");
		op(`CSF_OP_SET_IRQ_GATE, 5'd0, 5'd0, 8'h00);
		chk(processor_status_flags, 16'h00C2);
		irq(8'h06);
		chk(irq_taken, 16'h0001);
		chk(irq_taken_id, 16'h0001);
		chk(irq_vector, 16'h0002);
		chk(processor_status_flags, 16'h0042);
		chk(stack_write, 16'h0001);
		chk(stack_addr, 16'h08FF);
		irq(8'h01);
		chk(irq_taken, 16'h0000);
		op(`CSF_OP_RETURN_FROM_INTERRUPT, 5'd0, 5'd0, 8'h00);
		chk(processor_status_flags, 16'h00C2);
		op(`CSF_OP_CLEAR_IRQ_GATE, 5'd0, 5'd0, 8'h00);
		chk(processor_status_flags, 16'h0042);
		$display("test irq done");
		ds(1'b0, 8'h5F, 8'h3C, 1'b1);
		chk(processor_status_flags, 16'h003C);
		ds(1'b1, 8'h3F, 8'h15, 1'b1);
		chk(processor_status_flags, 16'h0015);
		ds(1'b0, 8'h5F, 8'h00, 1'b0);
		chk(ds_rdata, 16'h0015);
		ds(1'b0, 8'h80, 8'hA7, 1'b1);
		chk({ext_sel, ext_write, 6'h00, ext_wdata}, 16'hC0A7);
		chk({8'h00, ext_addr}, 16'h0080);
		ds(1'b1, 8'h20, 8'h5A, 1'b1);
		chk(ext_sel, 16'h0000);
		$display("test map done");
		op(`CSF_OP_SELF_PROGRAM_WRITE, 5'd0, 5'd0, 8'h00);
		chk(self_program_write, 16'h0000);
		op(`CSF_OP_CALL, 5'd0, 5'd0, 8'h00);
		chk({stack_write, prog_addr[14:0]}, 16'h9000);
		op(`CSF_OP_SELF_PROGRAM_WRITE, 5'd0, 5'd0, 8'h00);
		chk(self_program_write, 16'h0001);
		chk(fetched_word, 16'hA490);
		op(`CSF_OP_CALL, 5'd0, 5'd0, 8'h00);
		chk(stack_data, 16'h9004);
		$display("test prog done");
		// A reset in mid-run must clear the flags and restart the fetch
		@(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(processor_status_flags, 16'h0000);
		chk(prog_addr, 16'h0000);
		@(posedge sys_clk);
		reset <= 1'b0;
		$display("test reset done");
		end_sim;
	end
endmodule
